// *** include/frtoc_pkg.sv ***
// Constants, encodings and state layout for the free-running timer with output compare
package frtoc_pkg;
    // Register byte offsets on the APB bus
    localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
    localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_CMP1_HIGH = 8'h0C;
    localparam logic [7:0] OFS_CMP1_LOW = 8'h10;
    localparam logic [7:0] OFS_CMP2_HIGH = 8'h14;
    localparam logic [7:0] OFS_CMP2_LOW = 8'h18;
    localparam logic [7:0] OFS_COUNT_HIGH = 8'h1C;
    localparam logic [7:0] OFS_COUNT_LOW = 8'h20;
    localparam logic [7:0] OFS_ALT_HIGH = 8'h24;
    localparam logic [7:0] OFS_ALT_LOW = 8'h28;

    // Control one fields
    localparam int CTL1_LEVEL1 = 0;
    localparam int CTL1_LEVEL2 = 2;
    localparam int CTL1_FORCE1 = 3;
    localparam int CTL1_FORCE2 = 4;
    localparam int CTL1_OVF_IE = 5;
    localparam int CTL1_CMP_IE = 6;
    localparam logic [7:0] CTL1_MASK = 8'h7D;
    // Control two fields
    localparam int CTL2_DIV_LO = 2;
    localparam int CTL2_DIV_HI = 3;
    localparam int CTL2_PIN_EN2 = 6;
    localparam int CTL2_PIN_EN1 = 7;
    localparam logic [7:0] CTL2_MASK = 8'hCC;
    // Status fields
    localparam int STS_CMP2 = 3;
    localparam int STS_OVF = 5;
    localparam int STS_CMP1 = 6;

    // Reset, reload, wrap and match-lag values
    localparam logic [15:0] COUNT_RELOAD = 16'hFFFC;
    localparam logic [15:0] COUNT_TOP = 16'hFFFF;
    localparam logic [15:0] CMP_RESET = 16'h8000;
    localparam logic [15:0] MATCH_LAG = 16'h0001;

    // Prescaler terminal counts
    localparam logic [2:0] PRE_MAX_DIV2 = 3'h1;
    localparam logic [2:0] PRE_MAX_DIV4 = 3'h3;
    localparam logic [2:0] PRE_MAX_DIV8 = 3'h7;

    typedef enum logic [1:0] {
        FRTOC_DIV4 = 2'b00,
        FRTOC_DIV2 = 2'b01,
        FRTOC_DIV8 = 2'b10,
        FRTOC_DIV_RSV = 2'b11
    } frtoc_div_e;

    typedef struct packed {
        logic [2:0] prescale;
        logic tick_d;
        logic [15:0] count;
        logic [7:0] low_buf;
        logic latched;
        logic ovf;
        logic arm_ovf;
        logic [1:0] cmp_flag;
        logic [1:0] arm_cmp;
        logic [1:0] inhibit;
        logic [7:0] ctrl_one;
        logic [7:0] ctrl_two;
        logic [1:0][15:0] cmp;
        logic [1:0] pin_latch;
        logic [1:0] pin_out;
        logic [1:0] pin_oe;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } frtoc_state_s;
endpackage

// *** design/frtoc_timer.sv ***
// Free-running 16-bit timer with prescaler, overflow flag and two output compare channels
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/100ps

module frtoc_timer #(
    parameter int ADDR_WIDTH = 8,
    parameter int NUM_CHANNELS = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpu_irq_mask,
    input wire logic halt_mode,
    output logic timer_irq,
    output logic [NUM_CHANNELS-1:0] compare_out_pin,
    output logic [NUM_CHANNELS-1:0] compare_pin_enable
);

    initial begin
        if (NUM_CHANNELS != 2 || ADDR_WIDTH < 8) begin
            $error("frtoc_timer serves exactly two channels and at least 8 address bits");
        end
    end

    frtoc_pkg::frtoc_state_s st;
    frtoc_pkg::frtoc_state_s nx;

    frtoc_pkg::frtoc_div_e div_sel;
    logic [2:0] pre_max;
    logic tick;
    logic set_ovf;
    logic [7:0] addr_byte;
    logic setup_phase;
    logic done;
    logic wr_done;
    logic rd_done;
    logic mapped;
    logic [7:0] rd_byte;
    logic [7:0] status_byte;
    logic reload;
    logic cnt_low_done;
    logic alt_low_done;
    logic status_rd_done;
    logic [1:0] cmp_high_wr;
    logic [1:0] cmp_low_wr;
    logic [1:0] cmp_low_done;
    logic [1:0] level;
    logic [1:0] force_bit;
    logic [1:0] pin_en;
    logic [1:0] match;
    logic [1:0][15:0] target;

    assign addr_byte = {paddr[7:2], 2'b00};
    assign setup_phase = psel && !penable;
    assign done = psel && penable && st.pready;
    assign wr_done = done && pwrite;
    assign rd_done = done && !pwrite;
    assign status_rd_done = rd_done && (addr_byte == frtoc_pkg::OFS_STATUS);
    assign cnt_low_done = done && (addr_byte == frtoc_pkg::OFS_COUNT_LOW);
    assign alt_low_done = done && (addr_byte == frtoc_pkg::OFS_ALT_LOW);
    assign reload = wr_done && ((addr_byte == frtoc_pkg::OFS_COUNT_LOW) ||
                                (addr_byte == frtoc_pkg::OFS_ALT_LOW));
    assign cmp_high_wr[0] = wr_done && (addr_byte == frtoc_pkg::OFS_CMP1_HIGH);
    assign cmp_high_wr[1] = wr_done && (addr_byte == frtoc_pkg::OFS_CMP2_HIGH);
    assign cmp_low_done[0] = done && (addr_byte == frtoc_pkg::OFS_CMP1_LOW);
    assign cmp_low_done[1] = done && (addr_byte == frtoc_pkg::OFS_CMP2_LOW);
    assign cmp_low_wr = cmp_low_done & {2{pwrite}};

    assign level = {st.ctrl_one[frtoc_pkg::CTL1_LEVEL2], st.ctrl_one[frtoc_pkg::CTL1_LEVEL1]};
    assign force_bit = {st.ctrl_one[frtoc_pkg::CTL1_FORCE2], st.ctrl_one[frtoc_pkg::CTL1_FORCE1]};
    assign pin_en = {st.ctrl_two[frtoc_pkg::CTL2_PIN_EN2], st.ctrl_two[frtoc_pkg::CTL2_PIN_EN1]};

    // Status layout with reserved bits at zero
    assign status_byte = {1'b0, st.cmp_flag[0], st.ovf, 1'b0, st.cmp_flag[1], 3'b000};

    // Tick divider and match offset
    always_comb begin
        div_sel = frtoc_pkg::frtoc_div_e'(
            st.ctrl_two[frtoc_pkg::CTL2_DIV_HI:frtoc_pkg::CTL2_DIV_LO]);
        case (div_sel)
            frtoc_pkg::FRTOC_DIV2: pre_max = frtoc_pkg::PRE_MAX_DIV2;
            frtoc_pkg::FRTOC_DIV8: pre_max = frtoc_pkg::PRE_MAX_DIV8;
            frtoc_pkg::FRTOC_DIV4: pre_max = frtoc_pkg::PRE_MAX_DIV4;
            default: pre_max = frtoc_pkg::PRE_MAX_DIV4;
        endcase
        // Halt freezes the prescaler and the count
        tick = !halt_mode && (st.prescale >= pre_max);
        set_ovf = tick && (st.count == frtoc_pkg::COUNT_TOP);
        for (int i = 0; i < 2; i++) begin
            if (div_sel == frtoc_pkg::FRTOC_DIV2) begin
                target[i] = st.cmp[i];
            end else begin
                target[i] = st.cmp[i] + frtoc_pkg::MATCH_LAG;
            end
            // Compare runs once per new count value
            match[i] = st.tick_d && !st.inhibit[i] && (st.count == target[i]);
        end
    end

    // Read data and address decode
    always_comb begin
        mapped = 1'b1;
        rd_byte = 8'h00;
        case (addr_byte)
            frtoc_pkg::OFS_CTRL_ONE: rd_byte = st.ctrl_one;
            frtoc_pkg::OFS_CTRL_TWO: rd_byte = st.ctrl_two;
            frtoc_pkg::OFS_STATUS: rd_byte = status_byte;
            frtoc_pkg::OFS_CMP1_HIGH: rd_byte = st.cmp[0][15:8];
            frtoc_pkg::OFS_CMP1_LOW: rd_byte = st.cmp[0][7:0];
            frtoc_pkg::OFS_CMP2_HIGH: rd_byte = st.cmp[1][15:8];
            frtoc_pkg::OFS_CMP2_LOW: rd_byte = st.cmp[1][7:0];
            frtoc_pkg::OFS_COUNT_HIGH: rd_byte = st.count[15:8];
            frtoc_pkg::OFS_ALT_HIGH: rd_byte = st.count[15:8];
            frtoc_pkg::OFS_COUNT_LOW, frtoc_pkg::OFS_ALT_LOW: begin
                rd_byte = st.latched ? st.low_buf : st.count[7:0];
            end
            default: mapped = 1'b0;
        endcase
    end

    always_comb begin
        nx = st;
        nx.pready = setup_phase;
        nx.pslverr = setup_phase && !mapped;
        if (setup_phase) begin
            nx.prdata = {24'h00_0000, rd_byte};
        end
        nx.tick_d = tick;
        if (!halt_mode) begin
            nx.prescale = tick ? 3'h0 : st.prescale + 3'h1;
        end
        if (tick) begin
            nx.count = st.count + 16'h0001;
        end
        if (reload) begin
            nx.count = frtoc_pkg::COUNT_RELOAD;
            nx.prescale = 3'h0;
        end
        if (wr_done && addr_byte == frtoc_pkg::OFS_CTRL_ONE) begin
            nx.ctrl_one = pwdata[7:0] & frtoc_pkg::CTL1_MASK;
        end
        if (wr_done && addr_byte == frtoc_pkg::OFS_CTRL_TWO) begin
            nx.ctrl_two = pwdata[7:0] & frtoc_pkg::CTL2_MASK;
        end
        if (status_rd_done) begin
            nx.arm_ovf = st.ovf;
            nx.arm_cmp = st.cmp_flag;
        end
        // High byte read latches the low byte once per pair
        // Taken at the setup edge, with the high byte, so a carry cannot tear the pair
        if (setup_phase && !pwrite && (addr_byte == frtoc_pkg::OFS_COUNT_HIGH ||
                                       addr_byte == frtoc_pkg::OFS_ALT_HIGH) && !st.latched) begin
            nx.low_buf = st.count[7:0];
            nx.latched = 1'b1;
        end
        if (rd_done && (cnt_low_done || alt_low_done)) begin
            nx.latched = 1'b0;
        end
        if (cnt_low_done) begin
            if (st.arm_ovf) begin
                nx.ovf = 1'b0;
            end
            nx.arm_ovf = 1'b0;
        end
        nx.ovf = nx.ovf || set_ovf;
        for (int i = 0; i < 2; i++) begin
            if (cmp_high_wr[i]) begin
                nx.cmp[i][15:8] = pwdata[7:0];
                nx.inhibit[i] = 1'b1;
            end
            if (cmp_low_wr[i]) begin
                nx.cmp[i][7:0] = pwdata[7:0];
                nx.inhibit[i] = 1'b0;
            end
            if (cmp_low_done[i]) begin
                if (st.arm_cmp[i]) begin
                    nx.cmp_flag[i] = 1'b0;
                end
                nx.arm_cmp[i] = 1'b0;
            end
            if (match[i]) begin
                nx.cmp_flag[i] = 1'b1;
                nx.pin_latch[i] = level[i];
            end
            // Forcing drives the pin straight from the level bit
            if (!pin_en[i]) begin
                nx.pin_out[i] = 1'b0;
            end else if (force_bit[i]) begin
                nx.pin_out[i] = level[i];
            end else begin
                nx.pin_out[i] = nx.pin_latch[i];
            end
            nx.pin_oe[i] = pin_en[i];
        end
        nx.irq = !cpu_irq_mask &&
                 ((nx.ovf && st.ctrl_one[frtoc_pkg::CTL1_OVF_IE]) ||
                  ((|nx.cmp_flag) && st.ctrl_one[frtoc_pkg::CTL1_CMP_IE]));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.count <= frtoc_pkg::COUNT_RELOAD;
            st.cmp[0] <= frtoc_pkg::CMP_RESET;
            st.cmp[1] <= frtoc_pkg::CMP_RESET;
        end else begin
            st <= nx;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign timer_irq = st.irq;
    assign compare_out_pin = st.pin_out;
    assign compare_pin_enable = st.pin_oe;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic sel_div2;
    assign sel_div2 = (div_sel == frtoc_pkg::FRTOC_DIV2);

    sequence s_div2_tick;
        tick && sel_div2;
    endsequence
    sequence s_div2_hold;
        sel_div2 && !halt_mode && !reload;
    endsequence
    sequence s_ovf_armed;
        status_rd_done && st.ovf;
    endsequence
    sequence s_ovf_low_access;
        cnt_low_done && !set_ovf;
    endsequence

    AST_DIV2_PERIOD: assert property (s_div2_tick ##1 s_div2_hold ##1 s_div2_hold
                                      |-> tick)
        else $error("divide by two tick period wrong");
    AST_RELOAD: assert property (reload |=> st.count == 16'hFFFC)
        else $error("counter low write did not reload");
    AST_OVF_SET: assert property (tick && st.count == 16'hFFFF && !reload
                                  |=> st.ovf && st.count == 16'h0000)
        else $error("overflow wrap did not set flag");
    AST_OVF_CLEAR: assert property (s_ovf_armed ##[2:3] s_ovf_low_access |=> !st.ovf)
        else $error("overflow flag not cleared by status then low access");
    AST_ALT_KEEPS_OVF: assert property (alt_low_done && st.ovf |=> st.ovf)
        else $error("alternate low access cleared overflow flag");
    AST_OVF_IRQ: assert property (st.ovf && st.ctrl_one[5] && !cpu_irq_mask
                                  ##1 st.ovf && !cpu_irq_mask |-> timer_irq)
        else $error("overflow interrupt not requested");
    AST_HALT_FREEZE: assert property (halt_mode && !reload |=> $stable(st.count))
        else $error("counter moved during halt");
    AST_CMP_SW_ONLY: assert property (!(|cmp_high_wr) && !(|cmp_low_wr)
                                      |=> $stable(st.cmp))
        else $error("compare register changed without a write");
    AST_INHIBIT: assert property (cmp_high_wr[0] ##1 !cmp_low_wr[0] [*2] |-> !match[0])
        else $error("compare active while inhibited");
    AST_NO_FLAG_WITHOUT_MATCH: assert property (!st.cmp_flag[1] && !match[1]
                                                |=> !st.cmp_flag[1])
        else $error("compare flag set without match");
    AST_PIN_DISABLED: assert property (!pin_en[0] |=>
                                       !compare_out_pin[0] && !compare_pin_enable[0])
        else $error("disabled compare pin driven");
    AST_STATUS_RSV: assert property (setup_phase && addr_byte == 8'h08 |=>
                                     prdata[7] == 1'b0 && prdata[4] == 1'b0
                                     && prdata[2:0] == 3'b000)
        else $error("reserved status bits not zero");
    AST_LATCH_HOLD: assert property (st.latched &&
                                     !(rd_done && (cnt_low_done || alt_low_done))
                                     |=> $stable(st.low_buf) && st.latched)
        else $error("latched low byte changed before low read");

endmodule

// *** sim/frtoc_pin_model.sv ***
// Board-side model of the two compare pins with their general-purpose pull-ups
`timescale 1ns/100ps

module frtoc_pin_model (
    input wire logic [1:0] drive,
    input wire logic [1:0] drive_en,
    output logic [1:0] pin_level
);
    // An undriven pin falls back to its pull-up as a general I/O line
    assign pin_level[0] = drive_en[0] ? drive[0] : 1'b1;
    assign pin_level[1] = drive_en[1] ? drive[1] : 1'b1;
endmodule

// *** sim/tb.sv ***
// Self-checking testbench for the free-running timer with output compare
`timescale 1ns/100ps

module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cpu_irq_mask = 1'b1;
    logic halt_mode = 1'b0;
    logic timer_irq;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
    logic [1:0] pin_level;
    logic err_seen;
    logic [31:0] seed = 32'ha7b6_c665;
    int num_errors = 0;
    int check_count = 0;

    always #5 pclk = ~pclk;

    frtoc_timer frtoc_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_irq_mask(cpu_irq_mask),
        .halt_mode(halt_mode), .timer_irq(timer_irq), .compare_out_pin(pin_out),
        .compare_pin_enable(pin_oe));

    frtoc_pin_model frtoc_pin_model_inst (.drive(pin_out), .drive_en(pin_oe),
        .pin_level(pin_level));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic close_out();
        $display("errors=%0d checks=%0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] r);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            num_errors++;
            close_out();
        end
        r = prdata[7:0];
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        bus(1'b0, a, 8'h00, r);
    endtask

    task automatic poll(input int bitn);
        logic [7:0] r;
        int n;
        n = 0;
        do begin
            rd(frtoc_pkg::OFS_STATUS, r);
            n++;
        end while (r[bitn] !== 1'b1 && n < 60);
        if (n >= 60) begin
            num_errors++;
            close_out();
        end
    endtask

    initial begin
        logic [7:0] r;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] aq[$];
        logic [7:0] eq[$];
        aq = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
        eq = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'hFF, 8'hFC};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        halt_mode <= 1'b1;
        foreach (aq[i]) begin
            rd(aq[i], r);
            check(r, eq[i]);
        end
        rd(8'h30, r);
        check({23'h00_0000, err_seen, r}, 32'h0000_0100);
        for (int i = 0; i < 3; i++) begin
            halt_mode <= 1'b1;
            wr(frtoc_pkg::OFS_CTRL_TWO, 8'(i << 2));
            wr(frtoc_pkg::OFS_COUNT_LOW, 8'h00);
            rd(frtoc_pkg::OFS_COUNT_HIGH, r);
            check(r, 8'hFF);
            rd(frtoc_pkg::OFS_COUNT_LOW, r);
            check(r, 8'hFC);
            halt_mode <= 1'b0;
            repeat (16 * (i == 0 ? 4 : i == 1 ? 2 : 8)) @(posedge pclk);
            halt_mode <= 1'b1;
            rd(frtoc_pkg::OFS_COUNT_LOW, r);
            a = r - 8'hFC;
            check(a, 8'h10);
        end
        halt_mode <= 1'b0;
        rd(frtoc_pkg::OFS_COUNT_HIGH, r);
        rd(frtoc_pkg::OFS_ALT_HIGH, r);
        repeat (40) @(posedge pclk);
        halt_mode <= 1'b1;
        rd(frtoc_pkg::OFS_COUNT_LOW, a);
        rd(frtoc_pkg::OFS_COUNT_LOW, b);
        check(8'(b - a) inside {[4:8]}, 1);
        rd(frtoc_pkg::OFS_ALT_LOW, r);
        check(r, b);
        halt_mode <= 1'b0;
        wr(frtoc_pkg::OFS_CTRL_TWO, 8'h04);
        wr(frtoc_pkg::OFS_CTRL_ONE, 8'h20);
        rd(frtoc_pkg::OFS_STATUS, r);
        wr(frtoc_pkg::OFS_COUNT_LOW, 8'h00);
        rd(frtoc_pkg::OFS_STATUS, r);
        check(r & 8'h20, 8'h00);
        poll(5);
        check(timer_irq, 0);
        cpu_irq_mask <= 1'b0;
        repeat (2) @(posedge pclk);
        check(timer_irq, 1);
        rd(frtoc_pkg::OFS_STATUS, r);
        rd(frtoc_pkg::OFS_ALT_LOW, r);
        rd(frtoc_pkg::OFS_STATUS, r);
        check(r & 8'h20, 8'h20);
        rd(frtoc_pkg::OFS_COUNT_LOW, r);
        rd(frtoc_pkg::OFS_STATUS, r);
        check(r & 8'h20, 8'h00);
        repeat (2) @(posedge pclk);
        check(timer_irq, 0);
        wr(frtoc_pkg::OFS_CTRL_TWO, 8'h84);
        wr(frtoc_pkg::OFS_CTRL_ONE, 8'h45);
        a = 8'(xs() & 32'h0000_003F) | 8'h40;
        b = 8'(xs());
        wr(frtoc_pkg::OFS_CMP2_HIGH, a);
        wr(frtoc_pkg::OFS_CMP2_LOW, b);
        rd(frtoc_pkg::OFS_CMP2_HIGH, r);
        check(r, a);
        rd(frtoc_pkg::OFS_CMP2_LOW, r);
        check(r, b);
        wr(frtoc_pkg::OFS_CMP1_HIGH, 8'h00);
        rd(frtoc_pkg::OFS_STATUS, r);
        wr(frtoc_pkg::OFS_CMP1_LOW, 8'h10);
        wr(frtoc_pkg::OFS_COUNT_LOW, 8'h00);
        poll(6);
        repeat (2) @(posedge pclk);
        check({pin_oe, pin_out}, 4'b0101);
        check(timer_irq, 1);
        rd(frtoc_pkg::OFS_STATUS, r);
        rd(frtoc_pkg::OFS_CMP1_LOW, r);
        rd(frtoc_pkg::OFS_STATUS, r);
        check(r & 8'h40, 8'h00);
        wr(frtoc_pkg::OFS_CMP1_HIGH, 8'h00);
        wr(frtoc_pkg::OFS_COUNT_LOW, 8'h00);
        repeat (80) @(posedge pclk);
        rd(frtoc_pkg::OFS_STATUS, r);
        check(r & 8'h40, 8'h00);
        wr(frtoc_pkg::OFS_CTRL_ONE, 8'h08);
        repeat (2) @(posedge pclk);
        check(pin_level[0], 0);
        wr(frtoc_pkg::OFS_CTRL_ONE, 8'h09);
        repeat (2) @(posedge pclk);
        check(pin_level[0], 1);
        rd(frtoc_pkg::OFS_STATUS, r);
        check(r & 8'h40, 8'h00);
        // Reset while halted: count, compare and pins come back at reset values
        halt_mode <= 1'b1;
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        check({pin_oe, pin_out}, 4'b0000);
        rd(frtoc_pkg::OFS_COUNT_HIGH, r);
        check(r, 8'hFF);
        rd(frtoc_pkg::OFS_COUNT_LOW, r);
        check(r, 8'hFC);
        rd(frtoc_pkg::OFS_CMP1_LOW, r);
        check(r, 8'h00);
        close_out();
    end
endmodule
